// *** src/srv_pkg.sv ***
package srv_pkg;

	// ----------------------------------------------------------------
	// status word layout
	// ----------------------------------------------------------------
	localparam int POS_NEG = 31;
	localparam int POS_ZERO = 30;
	localparam int POS_CARRY = 29;
	localparam int POS_OVF = 28;
	localparam int POS_SAT = 27;
	localparam int POS_THUMB = 24;
	localparam int CONT_HI_LSB = 25;
	localparam int CONT_HI_W = 2;
	localparam int CONT_LO_LSB = 10;
	localparam int CONT_LO_W = 6;
	localparam int EXC_W = 9;

	// parts of the word, as masks
	localparam logic [31:0] APP_MASK = 32'hf800_0000;
	localparam logic [31:0] EXEC_MASK = 32'h0700_fc00;
	localparam logic [31:0] IRQ_MASK = 32'h0000_01ff;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] RST_FLAGS = 5'h00;
	localparam logic RST_THUMB = 1'h1;
	localparam logic [7:0] RST_CONT = 8'h00;
	localparam logic [EXC_W-1:0] RST_EXC = 9'h000;
	localparam logic [7:0] RST_PENDING = 8'h00;

	// ----------------------------------------------------------------
	// register views selected by the move instructions
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		VIEW_FULL,
		VIEW_APP,
		VIEW_EXEC,
		VIEW_IRQ,
		VIEW_EXEC_IRQ,
		VIEW_APP_IRQ,
		VIEW_APP_EXEC
	} srv_view_t;

	// ----------------------------------------------------------------
	// memory regions, top address bits
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_PERIPH = 3'h2;
	localparam logic [2:0] REG_EXTDEV_A = 3'h5;
	localparam logic [2:0] REG_EXTDEV_B = 3'h6;
	localparam logic [2:0] REG_SYSTEM = 3'h7;
	localparam logic [11:0] PPB_TOP = 12'he00;

endpackage

// *** src/srv_order_gate.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------
// memory issue gate: barrier hold and region class
// ----------------------------------------------------------------
module srv_order_gate import srv_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request side
	input wire logic reqValid,
	input wire logic [31:0] reqAddr,
	input wire logic barrier,
	input wire logic ack,
	// issue side
	output logic issue,
	output logic isDevice,
	output logic isStrong,
	output logic barrierBusy
);

	typedef struct packed {
		logic [7:0] pending;
		logic hold;
		logic issue;
		logic isDevice;
		logic isStrong;
	} srv_gate_t;

	srv_gate_t s_q, s_d;
	logic strongReq;
	logic devReq;

	// region class of the incoming address
	always_comb begin
		strongReq = (reqAddr[31:29] == REG_SYSTEM) && (reqAddr[31:20] == PPB_TOP);
		// peripheral and vendor regions carry only device-type ordering
		devReq = (reqAddr[31:29] == REG_PERIPH) || (reqAddr[31:29] == REG_EXTDEV_A) ||
			(reqAddr[31:29] == REG_EXTDEV_B) || ((reqAddr[31:29] == REG_SYSTEM) && !strongReq);
	end

	// next state
	always_comb begin
		logic go;
		go = 1'b0;
		s_d = s_q;
		if (barrier) begin
			s_d.hold = 1'b1;
		end else if (s_q.hold && s_q.pending == RST_PENDING) begin
			s_d.hold = 1'b0;
		end
		// outstanding accesses block only a new strongly-ordered request: other requests may be reordered
		go = reqValid && !s_q.hold && !barrier && !(strongReq && s_q.pending != RST_PENDING);
		s_d.issue = go;
		s_d.isDevice = go && devReq;
		s_d.isStrong = go && strongReq;
		if (go && !ack) begin
			s_d.pending = s_q.pending + 8'h01;
		end else if (!go && ack && s_q.pending != RST_PENDING) begin
			s_d.pending = s_q.pending - 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '{RST_PENDING, 1'b0, 1'b0, 1'b0, 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign issue = s_q.issue;
	assign isDevice = s_q.isDevice;
	assign isStrong = s_q.isStrong;
	assign barrierBusy = s_q.hold;

	a_barrier_hold: assert property (@(posedge clk) disable iff (rst) s_q.hold |=> !issue)
		else $error("issue while barrier pending");

endmodule // srv_order_gate

// *** src/srv_status_regs.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------
// program status word with its move views
// ----------------------------------------------------------------
// Function
// - the word holds N at 31, Z at 30, C at 29, V at 28, Q at 27, T at 24 and the exception number at the bottom.
// - the three parts are reachable singly, in any pair or all together, chosen by the view code of a move.
// - the full view merges all parts, exec-plus-irq is read-only, app-plus-irq and app-plus-exec are writable.
// - write data aimed at the exception number is dropped and that number keeps its value.
// - execution-state bits read as zero through a view and writes to them do nothing.
// - the condition flags keep the value left by the last flag-setting operation or flag-writing move.
// - N is 1 for a negative or less-than result and 0 otherwise.
// - Z is 1 for a zero result and 0 otherwise.
// - peripheral and vendor device regions add no constraints beyond device ordering.
// - memory accesses may issue out of program order where the sequence's behaviour is unchanged.
module srv_status_regs import srv_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// flag update from the execute stage
	input wire logic flagSet,
	input wire logic [31:0] aluResult,
	input wire logic aluCarry,
	input wire logic aluOverflow,
	input wire logic satSet,
	// execution state from the decode stage
	input wire logic execLoad,
	input wire logic execThumb,
	input wire logic [7:0] execCont,
	// exception entry and return
	input wire logic excLoad,
	input wire logic [EXC_W-1:0] excNum,
	// move-to-special request
	input wire logic msrValid,
	input wire logic [2:0] msrView,
	input wire logic [31:0] msrData,
	// move-from-special request
	input wire logic mrsValid,
	input wire logic [2:0] mrsView,
	// memory requests
	input wire logic memReqValid,
	input wire logic [31:0] memReqAddr,
	input wire logic memBarrier,
	input wire logic memAck,
	// read answer and move-to refusal
	output logic [31:0] mrsData,
	output logic mrsDone,
	output logic msrRefused,
	// state seen by the core
	output logic [31:0] statusWord,
	// memory issue
	output logic memIssue,
	output logic memDevice,
	output logic memStrong,
	output logic memBarrierBusy
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] flags;
		logic thumb;
		logic [7:0] cont;
		logic [EXC_W-1:0] exc;
		logic [31:0] rdData;
		logic rdValid;
		logic refused;
	} srv_state_t;

	srv_state_t s_q, s_d;
	logic [31:0] fullWord;
	logic [31:0] rdMask;
	logic [31:0] wrMask;

	// view code to the parts it covers
	function automatic logic [2:0] view_parts(input logic [2:0] v);
		logic [2:0] p;
		p = 3'h0;
		case (srv_view_t'(v))
			VIEW_FULL: p = 3'h7;
			VIEW_APP: p = 3'h4;
			VIEW_EXEC: p = 3'h2;
			VIEW_IRQ: p = 3'h1;
			VIEW_EXEC_IRQ: p = 3'h3;
			VIEW_APP_IRQ: p = 3'h5;
			VIEW_APP_EXEC: p = 3'h6;
			default: p = 3'h0;
		endcase
		return p; // {app, exec, irq}
	endfunction

	// ----------------------------------------------------------------
	// word assembly and view masks
	// ----------------------------------------------------------------
	always_comb begin
		logic [2:0] rp;
		logic [2:0] wp;
		rp = view_parts(mrsView);
		wp = view_parts(msrView);
		fullWord = 32'h0000_0000; // reserved bits stay zero
		fullWord[POS_NEG:POS_SAT] = s_q.flags;
		fullWord[POS_THUMB] = s_q.thumb;
		fullWord[CONT_HI_LSB +: CONT_HI_W] = s_q.cont[7:6];
		fullWord[CONT_LO_LSB +: CONT_LO_W] = s_q.cont[5:0];
		fullWord[EXC_W-1:0] = s_q.exc;
		// execution part never reaches a read, reserved bits are outside every mask
		rdMask = (rp[2] ? APP_MASK : 32'h0000_0000) | (rp[0] ? IRQ_MASK : 32'h0000_0000);
		// only the flags can take write data
		wrMask = wp[2] ? APP_MASK : 32'h0000_0000;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic roView;
		roView = srv_view_t'(msrView) == VIEW_EXEC_IRQ;
		s_d = s_q;
		s_d.rdValid = mrsValid;
		s_d.rdData = mrsValid ? (fullWord & rdMask) : s_q.rdData;
		s_d.refused = msrValid && (roView || srv_view_t'(msrView) > VIEW_APP_EXEC);
		// move-to writes the flags first; a flag-setting operation in the same cycle overrides N, Z, C and V
		if (msrValid && !s_d.refused && wrMask[POS_NEG]) begin
			s_d.flags = msrData[POS_NEG:POS_SAT];
		end
		if (flagSet) begin
			s_d.flags[4] = aluResult[31];
			s_d.flags[3] = aluResult == 32'h0000_0000;
			s_d.flags[2] = aluCarry;
			s_d.flags[1] = aluOverflow;
		end
		// saturation is sticky: only a move clears it
		if (satSet) begin
			s_d.flags[0] = 1'b1;
		end
		if (execLoad) begin
			s_d.thumb = execThumb;
			s_d.cont = execCont;
		end
		// exception number changes only on entry or return, never by a move
		if (excLoad) begin
			s_d.exc = excNum;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '{RST_FLAGS, RST_THUMB, RST_CONT, RST_EXC, 32'h0000_0000, 1'b0, 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign mrsData = s_q.rdData;
	assign mrsDone = s_q.rdValid;
	assign msrRefused = s_q.refused;
	assign statusWord = fullWord;

	// ----------------------------------------------------------------
	// memory ordering gate
	// ----------------------------------------------------------------
	srv_order_gate u_gate (
		.clk(clk),
		.rst(rst),
		.reqValid(memReqValid),
		.reqAddr(memReqAddr),
		.barrier(memBarrier),
		.ack(memAck),
		.issue(memIssue),
		.isDevice(memDevice),
		.isStrong(memStrong),
		.barrierBusy(memBarrierBusy)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence mrs_full_req;
		mrsValid && srv_view_t'(mrsView) == VIEW_FULL;
	endsequence

	sequence answer_next;
		##1 mrsDone;
	endsequence

	a_neg_flag: assert property (flagSet |=> statusWord[POS_NEG] == $past(aluResult[31]))
		else $error("negative flag does not follow result sign");

	a_zero_flag: assert property (flagSet |=> statusWord[POS_ZERO] == ($past(aluResult) == 32'h0000_0000))
		else $error("zero flag does not follow result");

	a_flags_hold: assert property (!flagSet && !msrValid && !satSet |=> $stable(statusWord[POS_NEG:POS_SAT]))
		else $error("flags changed without a cause");

	a_exec_zero: assert property (mrsDone |-> (mrsData & EXEC_MASK) == 32'h0000_0000)
		else $error("execution bits visible in a read");

	a_reserved_zero: assert property (mrsDone |-> (mrsData & ~(APP_MASK | EXEC_MASK | IRQ_MASK)) == 32'h0000_0000)
		else $error("reserved bits not zero");

	a_irq_kept: assert property (msrValid && !excLoad |=> statusWord[EXC_W-1:0] == $past(statusWord[EXC_W-1:0]))
		else $error("move changed the exception number");

	a_ro_refused: assert property (msrValid && srv_view_t'(msrView) == VIEW_EXEC_IRQ |=> msrRefused)
		else $error("read-only view write not refused");

	a_app_write: assert property (msrValid && srv_view_t'(msrView) == VIEW_APP_EXEC && !flagSet && !satSet
		|=> statusWord[POS_NEG:POS_SAT] == $past(msrData[POS_NEG:POS_SAT]))
		else $error("writable view did not take flags");

	a_full_read: assert property (mrs_full_req |-> answer_next ##0 mrsData == ($past(statusWord) & ~EXEC_MASK))
		else $error("full view read wrong");

	a_word_layout: assert property (execLoad |=> statusWord[POS_THUMB] == $past(execThumb)
		&& statusWord[23:16] == 8'h00)
		else $error("status word layout wrong");

	// ----------------------------------------------------------------
	// checks on the move views
	// ----------------------------------------------------------------
	// a write through the read-only or the undefined view
	sequence msr_bad_req;
		msrValid && (srv_view_t'(msrView) == VIEW_EXEC_IRQ || msrView == 3'h7);
	endsequence

	// the refusal shows for exactly one cycle
	sequence refuse_once;
		msrRefused ##1 !msrRefused;
	endsequence

	// a lone read request with a quiet cycle after it
	sequence mrs_single_req;
		mrsValid ##1 !mrsValid;
	endsequence

	// the read answer shows for exactly one cycle
	sequence done_once;
		mrsDone ##1 !mrsDone;
	endsequence

	a_bad_view_refused: assert property (msrValid && msrView == 3'h7 |=> msrRefused)
		else $error("undefined view write not refused");

	a_good_view_taken: assert property (msrValid && msrView != 3'h7 && srv_view_t'(msrView) != VIEW_EXEC_IRQ
		|=> !msrRefused)
		else $error("writable view write refused");

	a_refuse_pulse: assert property (msr_bad_req ##1 !msrValid |-> refuse_once)
		else $error("refusal is not a single pulse");

	a_read_pulse: assert property (mrs_single_req |-> done_once)
		else $error("read answer is not a single pulse");

	a_read_hold: assert property (!mrsValid |=> $stable(mrsData))
		else $error("read data changed without a read");

	a_app_read: assert property (mrsValid && srv_view_t'(mrsView) == VIEW_APP
		|=> mrsData == ($past(statusWord) & APP_MASK))
		else $error("application view read wrong");

	a_irq_read: assert property (mrsValid && srv_view_t'(mrsView) == VIEW_IRQ
		|=> mrsData == ($past(statusWord) & IRQ_MASK))
		else $error("interrupt view read wrong");

	a_exec_read: assert property (mrsValid && srv_view_t'(mrsView) == VIEW_EXEC |=> mrsData == 32'h0000_0000)
		else $error("execution view read not zero");

	a_bad_view_read: assert property (mrsValid && mrsView == 3'h7 |=> mrsData == 32'h0000_0000)
		else $error("undefined view read not zero");

	a_app_irq_write: assert property (msrValid && srv_view_t'(msrView) == VIEW_APP_IRQ && !flagSet && !satSet
		|=> statusWord[POS_NEG:POS_SAT] == $past(msrData[POS_NEG:POS_SAT]))
		else $error("application plus irq view did not take flags");

	a_exec_kept: assert property (msrValid && !execLoad
		|=> (statusWord & EXEC_MASK) == ($past(statusWord) & EXEC_MASK))
		else $error("move changed execution bits");

	// ----------------------------------------------------------------
	// checks on the flags, the exception number and the execution state
	// ----------------------------------------------------------------
	a_carry_flag: assert property (flagSet |=> statusWord[POS_CARRY] == $past(aluCarry))
		else $error("carry flag does not follow operation");

	a_ovf_flag: assert property (flagSet |=> statusWord[POS_OVF] == $past(aluOverflow))
		else $error("overflow flag does not follow operation");

	a_sat_sticky: assert property (satSet |=> statusWord[POS_SAT])
		else $error("saturation flag not set");

	a_exc_load: assert property (excLoad |=> statusWord[EXC_W-1:0] == $past(excNum))
		else $error("exception number not loaded");

	a_cont_layout: assert property (execLoad |=> {statusWord[CONT_HI_LSB +: CONT_HI_W],
		statusWord[CONT_LO_LSB +: CONT_LO_W]} == $past(execCont))
		else $error("continuation bits misplaced");

endmodule // srv_status_regs

// *** verif/testbench.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------
// status word bench
// ----------------------------------------------------------------
module testbench import srv_pkg::*;;
	logic clk = 0, rst = 1;
	logic flagSet = 0, aluCarry = 0, aluOverflow = 0, satSet = 0;
	logic execLoad = 0, execThumb = 0, excLoad = 0, msrValid = 0, mrsValid = 0;
	logic memReqValid = 0, memBarrier = 0, memAck = 0;
	logic [31:0] aluResult = '0, msrData = '0, memReqAddr = '0;
	logic [7:0] execCont = '0;
	logic [EXC_W-1:0] excNum = '0;
	logic [2:0] msrView = '0, mrsView = '0;
	logic [31:0] mrsData, statusWord;
	logic mrsDone, msrRefused, memIssue, memDevice, memStrong, memBarrierBusy;
	int errors = 0, total_checks = 0;
	// readable bits per view code; execution bits never show through a view
	logic [31:0] viewMask [8] = '{APP_MASK | IRQ_MASK, APP_MASK, 32'h0, IRQ_MASK, IRQ_MASK,
		APP_MASK | IRQ_MASK, APP_MASK, 32'h0};

	srv_status_regs uut (.clk, .rst, .flagSet, .aluResult, .aluCarry, .aluOverflow, .satSet,
		.execLoad, .execThumb, .execCont, .excLoad, .excNum, .msrValid, .msrView, .msrData,
		.mrsValid, .mrsView, .memReqValid, .memReqAddr, .memBarrier, .memAck, .mrsData, .mrsDone,
		.msrRefused, .statusWord, .memIssue, .memDevice, .memStrong, .memBarrierBusy);

	// 100 ns period clock
	always #50 clk = ~clk;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task results;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// move-from: answer waited for under a bound
	task move_from_special_instr(input logic [2:0] v, output logic [31:0] d);
		int i;
		mrsView = v;
		mrsValid = 1;
		cyc(1);
		mrsValid = 0;
		for (i = 0; i < 4 && mrsDone !== 1'b1; i++) cyc(1);
		if (i == 4) begin
			chk("mrsDoneWait", 0, 1);
			results;
		end
		chk("mrsLatency", i, 0);
		d = mrsData;
		// a quiet cycle keeps two reads from touching the strobe in one step
		cyc(1);
		chk("mrsDonePulse", mrsDone, 0);
	endtask

	// move-to, then judge the word and the refusal pulse
	task wr(input logic [2:0] v, input logic [31:0] d, input logic [31:0] ew, input logic er);
		msrView = v;
		msrData = d;
		msrValid = 1;
		cyc(1);
		msrValid = 0;
		chk("wrRefused", msrRefused, er);
		cyc(1);
		chk("wrRefusedEnd", msrRefused, 0);
		chk("wrWord", statusWord, ew);
	endtask

	// hold a request until it issues; the bound stands in for a hang
	task memReq(input logic [31:0] a, input logic [1:0] cls);
		int i;
		memReqAddr = a;
		memReqValid = 1;
		for (i = 0; i < 6 && memIssue !== 1'b1; i++) cyc(1);
		chk("memIssued", i < 6, 1);
		if (i == 6) begin
			results;
		end
		// the class stands only in the issue cycle
		chk("memClass", {memDevice, memStrong}, cls);
		memReqValid = 0;
		cyc(1);
	endtask

	task pulseAck;
		memAck = 1;
		cyc(1);
		memAck = 0;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_flags;
		chk("resetWord", statusWord, 32'h0100_0000);
		aluResult = 0;
		aluCarry = 1;
		flagSet = 1;
		cyc(1);
		flagSet = 0;
		cyc(1);
		chk("zeroRes", statusWord[31:27], 5'b01100);
		aluResult = 32'h8000_0001;
		aluCarry = 0;
		aluOverflow = 1;
		flagSet = 1;
		satSet = 1;
		cyc(1);
		flagSet = 0;
		satSet = 0;
		cyc(1);
		chk("negRes", statusWord[31:27], 5'b10011);
		aluResult = 32'h5;
		aluOverflow = 0;
		flagSet = 1;
		cyc(1);
		flagSet = 0;
		cyc(4);
		chk("posRes", statusWord[31:27], 5'b00001);
	endtask

	task t_views;
		logic [31:0] d;
		execThumb = 1;
		execCont = 8'hff;
		execLoad = 1;
		excNum = 9'h1a5;
		excLoad = 1;
		cyc(1);
		execLoad = 0;
		excLoad = 0;
		cyc(1);
		chk("fullWord", statusWord, 32'h0f00_fda5);
		for (int v = 0; v < 8; v++) begin
			move_from_special_instr(v[2:0], d);
			chk("viewRead", d, 32'h0800_01a5 & viewMask[v]);
		end
		wr(VIEW_APP_IRQ, 32'hffff_ffff, 32'hff00_fda5, 0);
		wr(VIEW_APP_EXEC, 32'h0, 32'h0700_fda5, 0);
		wr(VIEW_EXEC_IRQ, 32'hffff_ffff, 32'h0700_fda5, 1);
		wr(VIEW_FULL, 32'ha0ff_ffff, 32'ha700_fda5, 0);
		wr(VIEW_APP, 32'h5800_0000, 32'h5f00_fda5, 0);
		wr(VIEW_EXEC, 32'hffff_ffff, 32'h5f00_fda5, 0);
		wr(VIEW_IRQ, 32'h0, 32'h5f00_fda5, 0);
		wr(3'h7, 32'h0, 32'h5f00_fda5, 1);
	endtask

	task t_mem;
		logic seen;
		memReq(32'h4000_0000, 2'b10);
		memReq(32'he010_0000, 2'b10);
		memReq(32'h2000_0000, 2'b00);
		memBarrier = 1;
		cyc(1);
		memBarrier = 0;
		memReqAddr = 32'h2000_0000;
		memReqValid = 1;
		seen = 0;
		repeat (3) begin
			cyc(1);
			seen |= memIssue;
		end
		chk("barrierBusy", memBarrierBusy, 1);
		chk("heldByBarrier", seen, 0);
		memAck = 1;
		cyc(3);
		memAck = 0;
		memReq(32'h2000_0000, 2'b00);
		chk("busyCleared", memBarrierBusy, 0);
		memReqAddr = 32'he000_0000;
		memReqValid = 1;
		seen = 0;
		repeat (3) begin
			cyc(1);
			seen |= memIssue;
		end
		chk("strongWaits", seen, 0);
		pulseAck;
		memReq(32'he000_0000, 2'b01);
		pulseAck;
	endtask

	// reset in mid-run with a barrier waiting and a read answer standing
	task t_reset;
		logic [31:0] d;
		move_from_special_instr(VIEW_FULL, d);
		chk("preRead", d, 32'h5800_01a5);
		memReq(32'h2000_0000, 2'b00);
		memBarrier = 1;
		cyc(1);
		memBarrier = 0;
		chk("busyBeforeReset", memBarrierBusy, 1);
		rst = 1;
		cyc(2);
		rst = 0;
		cyc(1);
		chk("rstWord", statusWord, 32'h0100_0000);
		chk("rstRead", mrsData, 32'h0000_0000);
		chk("rstBusy", memBarrierBusy, 0);
		wr(VIEW_APP, 32'hf800_0000, 32'hf900_0000, 0);
	endtask

	// main sequence
	initial begin
		cyc(16);
		rst = 0;
		cyc(1);
		t_flags;
		t_views;
		t_mem;
		t_reset;
		results;
	end
endmodule // testbench
